/* rtl/mra_top.v */
// Relocation register file, register selection, mapping and abort logic.
// Assumes microsequencer supplies decoded operation strobes on ref_clk.
`include "mra_defs.vh"
// Notes on behaviour
// - Mode option selects kernel, previous, console, current
// - Console uses console pair, 22-bit, no aborts
// - Instruction stream uses current mode bits
// - Data space only when requested, enabled, permitted
// - Page select is virtual address bits 15:13
// - Six access bits select one register pair
// - Two mux bits pick upper, lower or none
// - Console descriptor is scratch, no bypass effect
// - Identity base reads page select, read-only
// - Identity descriptor bits 15,9,8 read zero
// - Enable bit clear selects 16-bit; bit 4 chooses width
// - 16-bit mapping adds block to identity base
// - 18-bit mapping uses base bits 11:0
// - 22-bit mapping uses full base field
// - Adder sums base field and block number
// - Input latch takes prefetch PC or source register
// - Results go to prefetch or data latches
// - Length check honours expansion direction
// - Abort on illegal mode, non-resident, length
// - Abort on write to read-only page
// - Abort output asserted low at T-25
// - Demand cycles record cause when flags clear
// - Prefetch ORs causes into prefetch status bit
module mra_top (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire istream_op,
    input wire dstream_op,
    input wire write_op,
    input wire demand_cycle,
    input wire t25_point,
    input wire [1:0] mode_option,
    input wire [1:0] space_bits,
    input wire [15:0] prefetch_virtual_pc,
    input wire [15:0] a_port_operand_bus,
    input wire [15:0] source_reg_data,
    input wire [15:0] processor_status_word,
    input wire [15:0] mm_control_reg3,
    input wire [7:0] access_code,
    input wire reg_write,
    input wire [15:0] reg_wdata,
    input wire status_write,
    input wire [15:0] status_wdata,
    output wire [15:0] mmu_data_bus,
    output reg [21:0] prefetch_physical_pc,
    output reg [3:0] prefetch_status,
    output reg [21:0] output_latch,
    output reg [1:0] bank_latch,
    output reg bypass_latch,
    output reg abort_latch,
    output reg [15:0] mm_status_reg0,
    output wire abort_out_n
);
    reg [15:0] base_mem [0:`MRA_ENTRIES-1];
    reg [15:0] desc_mem [0:`MRA_ENTRIES-1];
    reg abort_pend_reg;
    reg [15:0] status_next;
    reg d_enable;
    reg [1:0] mode_sel;
    reg [15:0] sel_base;
    reg [15:0] sel_desc;
    reg [15:0] mux_out;
    wire relocating;
    wire console;
    wire enable;
    wire map16;
    wire map22;
    wire d_space;
    wire [2:0] page_sel;
    wire [5:0] rel_code;
    wire [5:0] reg_code;
    wire [15:0] virt_addr;
    wire length_error;
    wire [21:0] phys_addr;
    wire aborts_on;
    wire cause_nonres;
    wire cause_length;
    wire cause_wp;
    wire any_abort;
    wire wr_upper;
    wire wr_lower;
    wire [`MRA_ENTRIES-1:0] desc_we;
    wire [`MRA_ENTRIES-1:0] base_we;
    genvar g;

    assign relocating = istream_op | dstream_op;
    assign enable = mm_status_reg0[0];

    // Mode: prefetch always current; data from option field
    always @* begin
        if (istream_op) begin
            mode_sel = processor_status_word[15:14];
        end else begin
            case (mode_option)
                `MRA_OPT_KERNEL: mode_sel = `MRA_MODE_KERNEL;
                `MRA_OPT_PREV: mode_sel = processor_status_word[13:12];
                `MRA_OPT_CUR: mode_sel = processor_status_word[15:14];
                default: mode_sel = `MRA_MODE_ILLEGAL;
            endcase
        end
    end

    assign console = dstream_op & (mode_option == `MRA_OPT_CONSOLE);
    assign map22 = console | (enable & mm_control_reg3[4]);
    assign map16 = ~console & ~enable;
    // Per-mode data space permission; the illegal mode borrows bit 2, harmless as it aborts anyway
    always @* begin
        case (mode_sel)
            2'h0: d_enable = mm_control_reg3[0];
            2'h1: d_enable = mm_control_reg3[1];
            default: d_enable = mm_control_reg3[2];
        endcase
    end

    // Data space needs request, enable and per-mode permission
    assign d_space = dstream_op & (space_bits != 2'h0) & enable & d_enable;
    // Page select comes straight from the live inputs
    assign page_sel = istream_op ? prefetch_virtual_pc[15:13] : a_port_operand_bus[15:13];
    assign rel_code = console ? `MRA_CODE_CONSOLE : (map16 ? `MRA_CODE_IDENT :
                      {mode_sel, d_space, page_sel});
    assign reg_code = relocating ? rel_code : access_code[5:0];

    // Whole pair read during relocation; identity base is synthesized, its descriptor masked
    always @* begin
        sel_base = base_mem[reg_code];
        sel_desc = desc_mem[reg_code];
        if (reg_code == `MRA_CODE_IDENT) begin
            sel_base = {6'h00, page_sel, 7'h00};
            sel_desc = desc_mem[reg_code] & `MRA_IDENT_DESC_MASK;
        end
        case (access_code[7:6])
            `MRA_MUX_UPPER: mux_out = sel_desc;
            `MRA_MUX_LOWER: mux_out = sel_base;
            default: mux_out = 16'h0000;
        endcase
    end
    assign mmu_data_bus = relocating ? 16'h0000 : mux_out;

    // Input latch is transparent; the whole relocation settles within the request cycle
    assign virt_addr = istream_op ? prefetch_virtual_pc : source_reg_data;

    mra_length_check u_len (
        .block_number(virt_addr[12:6]),
        .length_field(sel_desc[14:8]),
        .expand_downward(sel_desc[3]),
        .length_error(length_error)
    );

    mra_mapper u_map (
        .virt_addr(virt_addr),
        .page_address_field(sel_base),
        .map16(map16),
        .map22(map22),
        .phys_addr(phys_addr)
    );

    assign aborts_on = enable & ~console;
    assign cause_nonres = (mode_sel == `MRA_MODE_ILLEGAL) | (sel_desc[2:1] == `MRA_ACF_NONRES0) |
                          (sel_desc[2:1] == `MRA_ACF_NONRES2);
    assign cause_length = length_error;
    assign cause_wp = dstream_op & write_op & (sel_desc[2:1] == `MRA_ACF_RO);
    assign any_abort = relocating & aborts_on & (cause_nonres | cause_length | cause_wp);

    // Abort shows only at T-25, held from the relocation cycle
    assign abort_out_n = ~(abort_pend_reg & t25_point);

    // Write strobes; relocation owns the file, so a microcode write in that cycle is dropped
    assign wr_upper = clk_en & reg_write & ~relocating & (access_code[7:6] == `MRA_MUX_UPPER);
    assign wr_lower = clk_en & reg_write & ~relocating & (access_code[7:6] == `MRA_MUX_LOWER) &
                      (reg_code != `MRA_CODE_IDENT);
    assign desc_we = {{(`MRA_ENTRIES-1){1'b0}}, wr_upper} << reg_code;
    assign base_we = {{(`MRA_ENTRIES-1){1'b0}}, wr_lower} << reg_code;

    // One entry per pair; each half has its own strobe
    generate
        for (g = 0; g < `MRA_ENTRIES; g = g + 1) begin : gen_entry
            // Descriptor half; the console entry is scratch and drives no bypass
            always @(posedge ref_clk) begin
                if (rst) begin
                    desc_mem[g] <= `MRA_REG_RESET;
                end else if (desc_we[g]) begin
                    desc_mem[g] <= reg_wdata;
                end
            end
            // Base half; the identity entry never takes a write, its view is synthesised
            always @(posedge ref_clk) begin
                if (rst) begin
                    base_mem[g] <= `MRA_REG_RESET;
                end else if (base_we[g]) begin
                    base_mem[g] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Status next value: software write first, hardware recording on top so the set wins
    always @* begin
        status_next = mm_status_reg0;
        if (status_write) begin
            status_next = {status_wdata[15:13], 6'h00, mm_status_reg0[6:1], status_wdata[0]};
        end
        // Recording is frozen while any flag is already set
        if (any_abort && demand_cycle && mm_status_reg0[15:13] == 3'h0) begin
            status_next[15:13] = {cause_nonres, cause_length, cause_wp};
        end
    end

    // Result latches and status recording
    always @(posedge ref_clk) begin
        if (rst) begin
            abort_pend_reg <= 1'b0;
            prefetch_physical_pc <= 22'h00_0000;
            prefetch_status <= 4'h0;
            output_latch <= 22'h00_0000;
            bank_latch <= 2'h0;
            bypass_latch <= 1'b0;
            abort_latch <= 1'b0;
            mm_status_reg0 <= 16'h0000;
        end else if (clk_en) begin
            if (relocating) begin
                abort_pend_reg <= any_abort;
            end else if (t25_point) begin
                abort_pend_reg <= 1'b0;
            end
            if (istream_op) begin
                prefetch_physical_pc <= phys_addr;
                prefetch_status <= {2'h0, 1'b0, any_abort};
            end
            if (dstream_op) begin
                output_latch <= phys_addr;
                bank_latch <= 2'h0;
                bypass_latch <= 1'b0;
                abort_latch <= any_abort;
            end
            mm_status_reg0 <= status_next;
        end
    end
endmodule

/* rtl/mra_defs.vh */
// Constants for the relocation and abort block: field positions, codes, widths.
// Assumes inclusion by bare name from files under rtl/.
`ifndef MRA_DEFS_VH
`define MRA_DEFS_VH
`define MRA_OPT_KERNEL 2'h0
`define MRA_OPT_PREV 2'h1
`define MRA_OPT_CONSOLE 2'h2
`define MRA_OPT_CUR 2'h3
`define MRA_MODE_KERNEL 2'h0
`define MRA_MODE_ILLEGAL 2'h2
`define MRA_MUX_UPPER 2'h2
`define MRA_MUX_LOWER 2'h1
// Identity and console pairs sit at illegal mode, I space, pages 6 and 7, so no real pair is shadowed
`define MRA_CODE_IDENT 6'h26
`define MRA_CODE_CONSOLE 6'h27
`define MRA_ACF_NONRES0 2'h0
`define MRA_ACF_RO 2'h1
`define MRA_ACF_NONRES2 2'h2
`define MRA_IDENT_DESC_MASK 16'h7cff
`define MRA_REG_RESET 16'h0000
`define MRA_ENTRIES 64
`endif

/* rtl/mra_length_check.v */
// Page length comparator: block number against descriptor length field.
// Assumes block number comes from the input latch, same clock.
module mra_length_check (
    input wire [6:0] block_number,
    input wire [6:0] length_field,
    input wire expand_downward,
    output wire length_error
);
    // Only the carry matters, so plain magnitude compares suffice
    assign length_error = expand_downward ? (block_number < length_field) :
                          (block_number > length_field);
endmodule

/* rtl/mra_mapper.v */
// Address adder and adjust logic for 16-, 18- and 22-bit mapping.
// Assumes base and virtual address are stable within the cycle.
module mra_mapper (
    input wire [15:0] virt_addr,
    input wire [15:0] page_address_field,
    input wire map16,
    input wire map22,
    output wire [21:0] phys_addr
);
    wire [15:0] sum;
    wire [21:0] pa16;
    wire [21:0] pa18;
    // Upper 16 bits are base plus block number
    assign sum = page_address_field + {9'h000, virt_addr[12:6]};
    assign pa16 = {{6{&sum[9:7]}}, sum[9:0], virt_addr[5:0]};
    assign pa18 = {{4{&sum[11:7]}}, sum[11:0], virt_addr[5:0]};
    assign phys_addr = map22 ? {sum, virt_addr[5:0]} : (map16 ? pa16 : pa18);
endmodule

/* testbench/mra_seq_model.sv */
// Sequencer stand-in: supplies the T-25 strobe in the cycle after each relocation request.
// Assumes one-cycle relocation requests on ref_clk.
module mra_seq_model (
    input logic ref_clk,
    input logic rst,
    input logic istream_op,
    input logic dstream_op,
    output logic t25_point
);
    timeunit 1ns;
    timeprecision 1ns;
    // Strobe lands in the cycle after the request, where the abort is due
    always @(posedge ref_clk) begin
        t25_point <= !rst && (istream_op || dstream_op);
    end
endmodule

/* testbench/mra_top_asserts.sv */
// Checker on the relocation block ports: abort timing, mapping, status flags.
// Assumes one clock ref_clk with synchronous active-high rst.
module mra_top_asserts (
    input logic ref_clk,
    input logic rst,
    input logic dstream_op,
    input logic status_write,
    input logic t25_point,
    input logic [1:0] mode_option,
    input logic [21:0] output_latch,
    input logic abort_latch,
    input logic [3:0] prefetch_status,
    input logic [15:0] mm_status_reg0,
    input logic abort_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Abort pin only moves at the strobe, and must follow a data or prefetch abort
    abort_strobe_a: assert property (!abort_out_n |-> t25_point && (abort_latch || prefetch_status[0]))
        else $error("abort off strobe");
    abort_due_a: assert property ($past(dstream_op) && abort_latch && t25_point |-> !abort_out_n)
        else $error("abort missing");
    // Console and disabled relocation never abort; disabled 16-bit mapping fills bits 21:16
    console_quiet_a: assert property (dstream_op && mode_option == 2'h2 |=> !abort_latch)
        else $error("console aborted");
    console_flags_a: assert property (dstream_op && mode_option == 2'h2 && !status_write
        |=> $stable(mm_status_reg0[15:13])) else $error("console flags");
    disabled_quiet_a: assert property (dstream_op && !mm_status_reg0[0] |=> !abort_latch)
        else $error("disabled abort");
    map16_top_a: assert property (dstream_op && !mm_status_reg0[0] && mode_option != 2'h2
        |=> output_latch[21:16] == {6{&output_latch[15:13]}}) else $error("16-bit top bits");
    // Set flags freeze recording; latches stand between relocations
    flags_hold_a: assert property (!status_write && mm_status_reg0[15:13] != 3'h0
        |=> $stable(mm_status_reg0[15:13])) else $error("flags changed");
    latches_stand_a: assert property (!dstream_op |=> $stable({abort_latch, output_latch}))
        else $error("latch moved");
endmodule
bind mra_top mra_top_asserts i_mra_top_asserts (.*);

/* testbench/mra_top_tb.sv */
// Bench: fills the relocation file, reads it back, checks random relocations against a model.
// Assumes the sequencer model strobes the T-25 point.
module mra_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, clk_en, istream_op, dstream_op, write_op, demand_cycle, t25_point, reg_write, status_write;
    logic bypass_latch, abort_latch, abort_out_n, is, con, sp, le;
    logic [1:0] mode_option, space_bits, bank_latch, md;
    logic [2:0] c;
    logic [3:0] prefetch_status;
    logic [5:0] ix;
    logic [7:0] access_code;
    logic [15:0] prefetch_virtual_pc, a_port_operand_bus, source_reg_data, processor_status_word, mm_control_reg3;
    logic [15:0] reg_wdata, status_wdata, mmu_data_bus, mm_status_reg0, va, ps, m3, r, v, b, d, dm[64], bm[64];
    logic [21:0] prefetch_physical_pc, output_latch, pa;
    int fail_count, comparisons, cyc, seed = 28173;
    mra_top i_mra_top (.*);
    mra_seq_model i_mra_seq_model (.*);
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // 100 MHz clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the ~500 cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) fail_count++;
        if (cyc > 3000) print_verdict();
    end
    // Reset, file fill and readback, then random relocations
    initial begin
        {istream_op, dstream_op, write_op, demand_cycle, reg_write, status_write, mode_option, space_bits} = 10'h000;
        {access_code, prefetch_virtual_pc, a_port_operand_bus, source_reg_data} = 56'h0;
        {processor_status_word, mm_control_reg3, reg_wdata, status_wdata} = 64'h0;
        {rst, clk_en} = 2'h3;
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        for (int i = 0; i < 256; i++) begin
            @(posedge ref_clk);
            v = $random(seed);
            if (i[5:0] == 6'h26) v &= 16'h7cff; // keep hardwired bits clear
            reg_write <= i < 128;
            reg_wdata <= v;
            access_code <= {i[6] ? 2'h1 : 2'h2, i[5:0]};
            if (i < 128 && i[6]) bm[i[5:0]] = i[5:0] == 6'h26 ? 16'h0000 : v; // identity base ignores writes
            if (i < 64) dm[i[5:0]] = v;
            #1;
            if (i > 127) chk(mmu_data_bus, i[6] ? bm[i[5:0]] : dm[i[5:0]]);
        end
        access_code <= 8'h00;
        for (int n = 0; n < 80; n++) begin
            {va, ps, m3, r} = {$random(seed), $random(seed)};
            is = r[1];
            md = is || r[3] ? ps[15:14] : r[2] ? ps[13:12] : 2'h0;
            con = !is && r[3:2] == 2'h2;
            if (md == 2'h2 || is) r[5:4] = 2'h0;
            sp = r[5:4] != 0 && r[0] && m3[md[1] ? 2 : md[0]];
            ix = con ? 6'h27 : r[0] ? {md, sp, va[15:13]} : 6'h26;
            b = ix == 6'h26 ? {6'h00, va[15:13], 7'h00} : bm[ix];
            d = dm[ix];
            pa = {b + va[12:6], va[5:0]};
            if (!con && !r[0]) pa[21:16] = {6{&pa[15:13]}};
            else if (!con && !m3[4]) pa[21:18] = {4{&pa[17:13]}};
            le = d[3] ? va[12:6] < d[14:8] : va[12:6] > d[14:8];
            c = {md == 2'h2 || !d[1], le, d[2:1] == 2'h1 && r[6] && !is} & {3{r[0] && !con}};
            @(posedge ref_clk);
            status_write <= 1;
            status_wdata <= {15'h0000, r[0]};
            @(posedge ref_clk);
            status_write <= 0;
            {istream_op, dstream_op, write_op, demand_cycle} <= {is, !is, r[6], r[7]};
            {mode_option, space_bits, processor_status_word, mm_control_reg3} <= {r[3:2], r[5:4], ps, m3};
            {prefetch_virtual_pc, source_reg_data, a_port_operand_bus} <= is ? {va, ~va, ~va} : {~va, va, va};
            @(posedge ref_clk);
            {istream_op, dstream_op} <= 2'h0;
            #1;
            chk(mm_status_reg0[15:13], r[7] ? c : 3'h0);
            if (is) chk({prefetch_physical_pc, prefetch_status, abort_out_n}, {pa, 3'h0, |c, !c});
            else chk({bypass_latch, bank_latch, output_latch, abort_latch, abort_out_n}, {3'h0, pa, |c, !c});
        end
        // Clock enable low must freeze the file: this write may not land
        @(posedge ref_clk);
        {clk_en, reg_write, access_code, reg_wdata} <= {1'b0, 1'b1, 8'h80, ~dm[0]};
        @(posedge ref_clk);
        {clk_en, reg_write} <= 2'h2;
        @(posedge ref_clk);
        #1;
        chk(mmu_data_bus, dm[0]);
        print_verdict();
    end
endmodule
